// ===== inc/iqd_pkg.sv
// Constants and types of the interrupt output stage.
// Assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus.
package iqd_pkg;
  // Register byte offsets; the direct-mapped window adds the base
  localparam logic [15:0] IQD_CFG_OFS = 16'h0054;
  localparam logic [15:0] IQD_STS_OFS = 16'h0058;
  localparam logic [15:0] IQD_ENA_OFS = 16'h005C;
  localparam logic [15:0] IQD_DIRECT_BASE = 16'h3000;
  // Field positions in interrupt_output_config
  localparam int IQD_DEAS_MSB = 31;
  localparam int IQD_DEAS_LSB = 24;
  localparam int IQD_CLR_BIT = 14;
  localparam int IQD_ACT_BIT = 13;
  localparam int IQD_MASTER_BIT = 12;
  localparam int IQD_EN_BIT = 8;
  localparam int IQD_POL_BIT = 4;
  localparam int IQD_CLKSEL_BIT = 1;
  localparam int IQD_TYPE_BIT = 0;
  // Power event source position in interrupt_source_status
  localparam int IQD_PME_BIT = 17;
  // Values after reset
  localparam logic [7:0] IQD_DEAS_RST = 8'h00;
  localparam logic IQD_EN_RST = 1'b0;
  localparam logic IQD_POL_RST = 1'b0;
  localparam logic IQD_CLKSEL_RST = 1'b0;
  localparam logic IQD_TYPE_RST = 1'b0;
  localparam logic [31:0] IQD_ENA_RST = 32'h0000_0000;
  // Interval unit: 10 us at a 40 ns clock
  localparam int IQD_DEAS_UNIT_NS = 10000;
  localparam int IQD_CLK_PERIOD_NS = 40;
  localparam int IQD_UNIT_CYCLES = IQD_DEAS_UNIT_NS / IQD_CLK_PERIOD_NS;
  localparam logic [7:0] IQD_UNIT_LAST = 8'(IQD_UNIT_CYCLES - 1);
  // AHB transfer type bit that marks an active transfer
  localparam int IQD_HTRANS_ACT = 1;
  // De-assertion timer states
  typedef enum logic [1:0] {
    IQD_IDLE = 2'b01,
    IQD_RUN = 2'b10
  } iqd_tmr_state_t;
endpackage

// ===== inc/iqd_timer_if.sv
// Link between the output stage and its de-assertion timer.
// Both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface iqd_timer_if;
  logic start;
  logic stop;
  logic [7:0] interval;
  logic active;
  modport ctl (output start, output stop, output interval, input active);
  modport tmr (input start, input stop, input interval, output active);
endinterface
`default_nettype wire

// ===== logic/iqd_deassert_timer.sv
// De-assertion interval timer, counted in 10 us units.
// Assumes start and stop are one-cycle pulses from the output stage.
`timescale 1ns/1ns
`default_nettype none
module iqd_deassert_timer
  import iqd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Control link
  iqd_timer_if.tmr tmr
);
  iqd_tmr_state_t state_reg, state_next;
  logic [7:0] unit_reg, unit_next;
  logic [7:0] ival_reg, ival_next;
  logic tick;

  // Unit prescaler restarts with each interval so every unit is whole
  always_comb
  begin
    state_next = state_reg;
    unit_next = unit_reg;
    ival_next = ival_reg;
    tick = (unit_reg == IQD_UNIT_LAST);
    case (state_reg)
      IQD_IDLE:
      begin
        if (tmr.start && tmr.interval != 8'h00)
        begin
          state_next = IQD_RUN;
        end
      end
      IQD_RUN:
      begin
        unit_next = tick ? 8'h00 : unit_reg + 8'h01;
        if (tick)
        begin
          ival_next = ival_reg + 8'h01;
          // Live field compare: a rewrite takes effect at once
          if (ival_next >= tmr.interval)
          begin
            state_next = IQD_IDLE;
          end
        end
      end
      default:
      begin
        state_next = IQD_IDLE;
      end
    endcase
    if (state_next == IQD_IDLE)
    begin
      unit_next = 8'h00;
      ival_next = 8'h00;
    end
    // Fresh interval even while one runs
    if (tmr.start && tmr.interval != 8'h00)
    begin
      state_next = IQD_RUN;
      unit_next = 8'h00;
      ival_next = 8'h00;
    end
    // Zero field stops and clears the count, stop wins
    if (tmr.stop)
    begin
      state_next = IQD_IDLE;
      unit_next = 8'h00;
      ival_next = 8'h00;
    end
  end

  // Timer registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= IQD_IDLE;
      unit_reg <= 8'h00;
      ival_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      unit_reg <= unit_next;
      ival_reg <= ival_next;
    end
  end

  assign tmr.active = (state_reg == IQD_RUN);
endmodule
`default_nettype wire

// ===== logic/iqd_irq_out.sv
// Interrupt output stage: master line, de-assertion gating, pin driver.
// Assumes level source status bits and a single AHB-Lite master.
// Functional notes
// - Interval field bits 31:24 counts in 10 us units.
// - Writing zero disables interval, clears counter, releases held interrupts.
// - A new non-zero interval applies at once, to a running interval as well.
// - Power event interrupt bypasses the de-assertion interval.
// - Writing one to bit 14 restarts the interval; bit self-clears.
// - Bit 13 reads one while interval active; interrupts withheld then.
// - Bit 12 shows the combined line, ignoring enable and interval.
// - Bit 8 gates the pin; zero keeps it de-asserted, except that bit 1 still routes the clock out.
// - Bit 4 picks active level: zero low, one high.
// - Open-drain mode ignores polarity and is always active low.
// - Bit 0 picks driver: zero open-drain, one push-pull.
// - Bit 1 routes the crystal clock onto the pin for debug.
// - Polarity and buffer type survive the digital soft reset.
// - Configuration register sits at 054h, or 3054h in direct mode.
// - An interval starts on every pin de-assertion.
// - Power event joins after interval gating; the line falling when it ends starts an interval.
`timescale 1ns/1ns
`default_nettype none
module iqd_irq_out
  import iqd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Interrupt sources
  input wire logic [31:0] irq_source_in,
  output logic [31:0] status_clear_out,
  // Device modes
  input wire logic direct_map_in,
  input wire logic soft_reset_in,
  input wire logic xtal_clk_in,
  // Interrupt pin
  output logic irq_pin_out,
  output logic irq_pin_oe_b_out
);
  iqd_timer_if tif ();

  logic [7:0] deas_field_reg, deas_field_next;
  logic en_reg, en_next;
  logic pol_reg, pol_next;
  logic clksel_reg, clksel_next;
  logic type_reg, type_next;
  logic [31:0] ena_reg, ena_next;
  logic irq_assert_reg, irq_assert_next;
  logic wr_pend_reg, wr_pend_next;
  logic rd_wait_reg, rd_wait_next;
  logic [1:0] sel_reg, sel_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] clr_reg, clr_next;
  logic [15:0] base;
  logic take;
  logic [1:0] sel_addr;
  logic wr_cfg;
  logic master_int;
  logic main_int;
  logic power_event_interrupt;
  logic [31:0] cfg_view;

  iqd_deassert_timer u_timer (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .tmr(tif.tmr)
  );

  // Address decode, direct_map_in picks which one of the two windows maps the registers
  assign base = direct_map_in ? IQD_DIRECT_BASE : 16'h0000;
  assign take = hsel_in && htrans_in[IQD_HTRANS_ACT] && hready_in;
  always_comb
  begin
    sel_addr = 2'd0;
    if (haddr_in[31:16] == 16'h0000)
    begin
      if (haddr_in[15:0] == (IQD_CFG_OFS | base))
      begin
        sel_addr = 2'd1;
      end
      else if (haddr_in[15:0] == (IQD_STS_OFS | base))
      begin
        sel_addr = 2'd2;
      end
      else if (haddr_in[15:0] == (IQD_ENA_OFS | base))
      begin
        sel_addr = 2'd3;
      end
    end
  end

  // Combined line and its split around the gating
  assign master_int = |(irq_source_in & ena_reg);
  assign power_event_interrupt = irq_source_in[IQD_PME_BIT] & ena_reg[IQD_PME_BIT];
  assign main_int = |(irq_source_in & ena_reg & ~(32'h1 << IQD_PME_BIT));

  // Readable view of the configuration register
  always_comb
  begin
    cfg_view = 32'h0000_0000;
    cfg_view[IQD_DEAS_MSB:IQD_DEAS_LSB] = deas_field_reg;
    cfg_view[IQD_ACT_BIT] = tif.active;
    cfg_view[IQD_MASTER_BIT] = master_int;
    cfg_view[IQD_EN_BIT] = en_reg;
    cfg_view[IQD_POL_BIT] = pol_reg;
    cfg_view[IQD_CLKSEL_BIT] = clksel_reg;
    cfg_view[IQD_TYPE_BIT] = type_reg;
  end

  assign wr_cfg = wr_pend_reg && (sel_reg == 2'd1);

  // Bus and configuration next state
  always_comb
  begin
    deas_field_next = deas_field_reg;
    en_next = en_reg;
    pol_next = pol_reg;
    clksel_next = clksel_reg;
    type_next = type_reg;
    ena_next = ena_reg;
    wr_pend_next = 1'b0;
    rd_wait_next = 1'b0;
    sel_next = sel_reg;
    rdata_next = rdata_reg;
    clr_next = 32'h0000_0000;
    tif.stop = 1'b0;
    // Data phase of a write
    if (wr_pend_reg)
    begin
      case (sel_reg)
        2'd1:
        begin
          deas_field_next = hwdata_in[IQD_DEAS_MSB:IQD_DEAS_LSB];
          en_next = hwdata_in[IQD_EN_BIT];
          pol_next = hwdata_in[IQD_POL_BIT];
          clksel_next = hwdata_in[IQD_CLKSEL_BIT];
          type_next = hwdata_in[IQD_TYPE_BIT];
          if (hwdata_in[IQD_DEAS_MSB:IQD_DEAS_LSB] == 8'h00)
          begin
            tif.stop = 1'b1;
          end
        end
        2'd2:
        begin
          clr_next = hwdata_in;
        end
        2'd3:
        begin
          ena_next = hwdata_in;
        end
        default:
        begin
          wr_pend_next = 1'b0;
        end
      endcase
    end
    // Address phase
    if (take)
    begin
      sel_next = sel_addr;
      wr_pend_next = hwrite_in;
      rd_wait_next = !hwrite_in;
    end
    // Read data sampled one cycle late so a write just before is seen
    if (rd_wait_reg)
    begin
      case (sel_reg)
        2'd1: rdata_next = cfg_view;
        2'd2: rdata_next = irq_source_in;
        2'd3: rdata_next = ena_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    // Soft reset keeps polarity and buffer type only
    if (soft_reset_in)
    begin
      deas_field_next = IQD_DEAS_RST;
      en_next = IQD_EN_RST;
      clksel_next = IQD_CLKSEL_RST;
      ena_next = IQD_ENA_RST;
      tif.stop = 1'b1;
    end
  end

  // Interval restart by the clear bit or by a falling pin
  assign tif.start = (wr_cfg && hwdata_in[IQD_CLR_BIT]) || (irq_assert_reg && !irq_assert_next);
  assign tif.interval = deas_field_next;

  // Assertion level: enable gates both the interval-gated main line and the power event
  always_comb
  begin
    irq_assert_next = 1'b0;
    if (en_reg)
    begin
      irq_assert_next = (main_int && !tif.active) || power_event_interrupt;
    end
  end

  // Registers, bus state and pin level
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      deas_field_reg <= IQD_DEAS_RST;
      en_reg <= IQD_EN_RST;
      pol_reg <= IQD_POL_RST;
      clksel_reg <= IQD_CLKSEL_RST;
      type_reg <= IQD_TYPE_RST;
      ena_reg <= IQD_ENA_RST;
      irq_assert_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      sel_reg <= 2'd0;
      rdata_reg <= 32'h0000_0000;
      clr_reg <= 32'h0000_0000;
    end
    else
    begin
      deas_field_reg <= deas_field_next;
      en_reg <= en_next;
      pol_reg <= pol_next;
      clksel_reg <= clksel_next;
      type_reg <= type_next;
      ena_reg <= ena_next;
      irq_assert_reg <= irq_assert_next;
      wr_pend_reg <= wr_pend_next;
      rd_wait_reg <= rd_wait_next;
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
      clr_reg <= clr_next;
    end
  end

  // Reads take one wait state; writes none; always OKAY
  assign hreadyout_out = !rd_wait_reg;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_reg;
  assign status_clear_out = clr_reg;

  // Pin driver; debug clock bypasses the flop, so it is not glitch-safe
  always_comb
  begin
    if (clksel_reg)
    begin
      irq_pin_out = type_reg ? xtal_clk_in : 1'b0;
      irq_pin_oe_b_out = type_reg ? 1'b0 : xtal_clk_in;
    end
    else if (type_reg)
    begin
      irq_pin_out = pol_reg ? irq_assert_reg : !irq_assert_reg;
      irq_pin_oe_b_out = 1'b0;
    end
    else
    begin
      irq_pin_out = 1'b0;
      irq_pin_oe_b_out = !irq_assert_reg;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_read_addr;
    take && !hwrite_in;
  endsequence
  sequence s_wait_ready;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  // Restart write with a live field and no soft reset racing it
  sequence s_clr_write;
    wr_cfg && hwdata_in[IQD_CLR_BIT] && hwdata_in[IQD_DEAS_MSB:IQD_DEAS_LSB] != 8'h00
      && !soft_reset_in;
  endsequence

  a_read_wait_state: assert property (s_read_addr |=> s_wait_ready)
    else $error("read did not complete after one wait state");
  a_disabled_pin_idle: assert property (!en_reg |=> !irq_assert_reg)
    else $error("pin asserted while output disabled");
  a_od_active_low: assert property (!clksel_reg && !type_reg && irq_assert_reg
    |-> !irq_pin_oe_b_out && !irq_pin_out)
    else $error("open-drain pin not pulled low when asserted");
  a_pp_level: assert property (!clksel_reg && type_reg
    |-> irq_pin_out == (irq_assert_reg ~^ pol_reg) && !irq_pin_oe_b_out)
    else $error("push-pull level does not follow polarity");
  a_deas_withhold: assert property (tif.active && !power_event_interrupt |=> !irq_assert_reg)
    else $error("interrupt reached pin during interval");
  a_pme_bypass: assert property (en_reg && power_event_interrupt |=> irq_assert_reg)
    else $error("power event interrupt was withheld");
  a_fall_starts: assert property (irq_assert_reg && !irq_assert_next && !tif.stop
    && deas_field_next != 8'h00 |=> tif.active [*2])
    else $error("no interval after pin de-assertion");
  a_zero_stops: assert property (tif.stop |=> !tif.active)
    else $error("interval still active after stop");
  a_clr_restart: assert property (s_clr_write |=> tif.active)
    else $error("clear bit did not start an interval");
  a_held_release: assert property ($fell(tif.active) && en_reg && main_int
    |=> irq_assert_reg)
    else $error("held interrupt not issued at interval end");
  a_soft_keeps: assert property (soft_reset_in && !wr_cfg
    |=> $stable(pol_reg) && $stable(type_reg) && !en_reg)
    else $error("soft reset handled polarity or enable wrongly");
endmodule
`default_nettype wire

// ===== verification/iqd_host_model.sv
// Host side of the interrupt pin: board pull-up and the wire the host sees.
// Assumes the device pin driver uses an active-low output enable.
`timescale 1ns/1ns
`default_nettype none
module iqd_host_model
(
  // Pin from the device
  input wire logic pin_in,
  input wire logic oe_b_in,
  // Resolved wire level seen by the host
  output logic line_out
);
  // Pull-up wins while nobody drives, so a released pin never shows a stale value
  assign line_out = oe_b_in ? 1'b1 : pin_in;
endmodule
`default_nettype wire

// ===== verification/irq_output_config_deassert_tb.sv
// Self-checking bench for the interrupt output stage.
// Assumes one AHB-Lite slave with hready looped back and a pulled-up pin.
`timescale 1ns/1ns
`default_nettype none
module irq_output_config_deassert_tb
  import iqd_pkg::*;
;
  localparam logic [31:0] CFG = {16'h0000, IQD_CFG_OFS};
  localparam logic [31:0] ENA = {16'h0000, IQD_ENA_OFS};
  localparam logic [31:0] STS = {16'h0000, IQD_STS_OFS};
  localparam logic [31:0] DIR = {16'h0000, IQD_DIRECT_BASE};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic dmap = 1'b0;
  logic srst = 1'b0;
  logic xtal = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] src = 32'h0;
  logic [31:0] rd;
  logic [31:0] c;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic [31:0] sclr;
  logic pin;
  logic oe_b;
  logic line;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int cnt;

  iqd_irq_out i_dut (.clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .irq_source_in(src), .status_clear_out(sclr), .direct_map_in(dmap), .soft_reset_in(srst),
    .xtal_clk_in(xtal), .irq_pin_out(pin), .irq_pin_oe_b_out(oe_b));
  iqd_host_model i_host (.pin_in(pin), .oe_b_in(oe_b), .line_out(line));

  // 25 MHz system clock
  always #20 clk = ~clk;

  // Hang guard: the run needs well under this many cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single transfer; the leading edge keeps back-to-back calls off one time step
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Expected wire level; open drain ignores polarity and relies on the pull-up
  function automatic logic exp_line(input logic asrt, input logic [31:0] cf);
    return cf[IQD_TYPE_BIT] ? (asrt ~^ cf[IQD_POL_BIT]) : ~asrt;
  endfunction

  // Cycles until the withheld line shows up, against n interval units
  task automatic measure(input logic [31:0] cf, input int n);
    tick(2);
    cnt = 2;
    while (line !== exp_line(1'b1, cf) && cnt < 3000)
    begin
      @(posedge clk);
      cnt++;
    end
    chk("interval cycles", 32'(cnt >= n * IQD_UNIT_CYCLES - 4 && cnt <= n * IQD_UNIT_CYCLES + 4), 32'h1);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(73923));
    tick(5);
    rst_b <= 1'b1;
    bus(1'b0, CFG, 32'h0);
    chk("cfg reset", rd, 32'h0);
    chk("pin idle", line, 32'h1);
    bus(1'b1, ENA, 32'h0002_0001);
    src <= 32'h1;
    for (int i = 0; i < 8; i++)
    begin
      c = {23'h0, i[2], 3'h0, i[1], 3'h0, i[0]};
      bus(1'b1, CFG, c);
      tick(3);
      chk("pin level", line, exp_line(i[2], c));
      bus(1'b0, CFG, 32'h0);
      chk("cfg readback", rd, c | 32'h1000);
    end
    // Interval withholds ordinary sources while the power event bypasses it
    c = 32'h0100_0111;
    bus(1'b1, CFG, c);
    tick(3);
    src <= 32'h0;
    tick(4);
    src <= 32'h1;
    tick(3);
    bus(1'b0, CFG, 32'h0);
    chk("active flag", rd, c | 32'h3000);
    chk("withheld", line, exp_line(1'b0, c));
    src <= 32'h0002_0001;
    tick(3);
    chk("power event", line, exp_line(1'b1, c));
    src <= 32'h1;
    tick(3);
    bus(1'b1, CFG, 32'h0000_0111);
    tick(2);
    chk("released", line, exp_line(1'b1, c));
    bus(1'b0, CFG, 32'h0);
    chk("flag cleared", rd, 32'h0000_1111);
    // Restart bit begins a full interval even with the line asserted
    bus(1'b1, CFG, 32'h0100_4111);
    measure(c, 1);
    bus(1'b0, CFG, 32'h0);
    chk("restart self clear", rd[IQD_CLR_BIT], 32'h0);
    // A later interval obeys the new field value
    bus(1'b1, CFG, 32'h0200_0111);
    src <= 32'h0;
    tick(2);
    src <= 32'h1;
    measure(32'h0200_0111, 2);
    // Soft reset keeps only polarity and driver type
    bus(1'b1, CFG, 32'h0500_0113);
    srst <= 1'b1;
    tick(1);
    srst <= 1'b0;
    bus(1'b0, CFG, 32'h0);
    chk("soft reset cfg", rd, 32'h0000_0011);
    bus(1'b0, ENA, 32'h0);
    chk("soft reset enable", rd, 32'h0);
    // Clock mode with push-pull, as the host must choose for a clean waveform
    bus(1'b1, CFG, 32'h0000_0103);
    for (int i = 0; i < 4; i++)
    begin
      xtal <= i[0];
      #5;
      chk("clock on pin", line, 32'(i[0]));
      @(posedge clk);
    end
    xtal <= 1'b0;
    // Random sources and enables through the direct-mapped window
    dmap <= 1'b1;
    bus(1'b1, DIR + CFG, 32'h0000_0011);
    for (int i = 0; i < 24; i++)
    begin
      c = $urandom();
      src <= $urandom();
      bus(1'b1, DIR + ENA, c);
      bus(1'b0, DIR + CFG, 32'h0);
      chk("master line", rd[IQD_MASTER_BIT], 32'(|(src & c)));
    end
    chk("bus response", hresp, 32'h0);
    // Status window reads the sources; a write gives a one-cycle clear pulse
    bus(1'b0, DIR + STS, 32'h0);
    chk("status read", rd, src);
    bus(1'b1, DIR + STS, c);
    tick(1);
    chk("status clear pulse", sclr, c);
    tick(1);
    chk("status clear ends", sclr, 32'h0);
    bus(1'b0, CFG, 32'h0);
    chk("window moved", rd, 32'h0);
    bus(1'b0, 32'h0000_3060, 32'h0);
    chk("unmapped read", rd, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
